// ### wrf_defines.vh
// Purpose: constants for the windowed register file
// Assumes: 40 MHz core clock, eight windows
// Notes: offsets are byte addresses on the plain register port
`ifndef WRF_DEFINES_VH
`define WRF_DEFINES_VH
`define WRF_NWIN 8
`define WRF_NPHYS 136
`define WRF_WIN_STRIDE 16
`define WRF_NWINREGS 128
// Register port offsets
`define WRF_ADDR_STATE 4'h0
`define WRF_ADDR_MASK 4'h4
`define WRF_ADDR_STATUS 4'h8
// State word field positions
`define WRF_SUP_BIT 7
`define WRF_PREV_SUP_BIT 6
`define WRF_WPTR_LSB 0
`define WRF_WPTR_MSB 4
// Operation codes on i_op
`define WRF_OP_NONE 3'h0
`define WRF_OP_SAVE 3'h1
`define WRF_OP_RESTORE 3'h2
`define WRF_OP_TRAP 3'h3
`define WRF_OP_TRAP_RETURN 3'h4
// Reset values
`define WRF_SUP_RST 1'h1
`endif

// ### windowed_register_file.v
// Purpose: windowed integer register file with window pointer control
// Assumes: decode issues one op per cycle; inputs synchronous to i_clk
// Notes: window pointer and mask are not reset; software sets them
//
// Decided for this implementation: the plain strobed port and the address map.
`default_nettype none
`include "wrf_defines.vh"

// Notes on behaviour
// - supervisor flag one means supervisor mode
// - control register access only in supervisor
// - any trap forces supervisor mode
// - trap return restores pre-trap supervisor flag
// - delayed return restores counters and flag
// - 136 registers of 32 bits
// - five-bit pointer selects 24-register window
// - register number decodes ins locals outs globals
// - numbers 0-7 always reach globals
// - window 7 adjoins window 0
// - ins shared with pointer+1 outs
// - pointer step shifts base by 16
// - pointer and mask left undefined at reset
// - save decrements, restore increments pointer
// - save adds; result into new window
// - save onto masked window raises overflow
// - restore/return onto masked window raises underflow
// - trapping check blocks the window change
// - trap decrements pointer without overflow check
// - mask bit n marks window n
// - global zero reads zero, writes dropped
// - trap saves counters into locals 1, 2
module windowed_register_file #(
  parameter DW = 32
) (
  input wire i_clk,
  input wire i_nrst,
  input wire [2:0] i_op,
  input wire [4:0] i_rs1,
  input wire [4:0] i_rs2,
  input wire [4:0] i_rd,
  input wire [DW-1:0] i_wdata,
  input wire i_we,
  input wire [DW-1:0] i_pc,
  input wire [DW-1:0] i_next_pc,
  input wire [3:0] i_addr,
  input wire [DW-1:0] i_wr_data,
  input wire i_wr,
  input wire i_rd_en,
  output reg [DW-1:0] o_rdata1,
  output reg [DW-1:0] o_rdata2,
  output reg [DW-1:0] o_rd_data,
  output reg o_supervisor,
  output reg [4:0] o_wptr,
  output reg o_overflow,
  output reg o_underflow,
  output reg o_priv_fault,
  output reg [DW-1:0] o_ret_pc,
  output reg [DW-1:0] o_ret_next_pc,
  output reg o_ret_valid
);

  localparam NW = `WRF_NWIN;
  localparam NP = `WRF_NPHYS;
  localparam NWR = `WRF_NWINREGS;
  localparam [7:0] GLOBAL_BASE = NWR[7:0];
  localparam [4:0] ZERO_REG = 5'h00;
  localparam [4:0] LOCAL1_REG = 5'h11;
  localparam [4:0] LOCAL2_REG = 5'h12;

  // Architectural state
  reg [DW-1:0] regs [0:NP-1];
  reg sup;
  reg prev_sup;
  reg [4:0] wptr;
  reg [NW-1:0] inv_mask;
  reg ovf_flag;
  reg unf_flag;
  reg priv_flag;

  // Physical index: globals above the 128 window regs
  // Window regs wrap mod 128, so window 7 ins are window 0 outs
  function [7:0] phys;
    input [4:0] rn;
    input [2:0] w;
    reg [7:0] base;
    begin
      base = {1'b0, w, 4'h0};
      if (rn[4:3] == 2'b00)
        phys = GLOBAL_BASE + {5'h00, rn[2:0]};
      else
        phys = {1'b0, base[6:0] + {2'b00, rn} - 7'h08};
    end
  endfunction

  // Decoded operation and access strobes
  wire [2:0] win;
  wire [2:0] win_dec;
  wire [2:0] win_inc;
  wire do_save;
  wire do_rest;
  wire do_trap;
  wire do_tret;
  wire save_ovf;
  wire rest_unf;
  wire priv_ok;
  wire ctl_access;
  wire bad_access;
  wire ctl_rd;
  wire state_wr;
  wire mask_wr;
  wire status_wr;
  wire clr_ovf;
  wire clr_unf;
  wire clr_priv;
  wire [7:0] idx_a;
  wire [7:0] idx_b;
  wire [7:0] idx_l1_trap;
  wire [7:0] idx_l2_trap;
  wire [7:0] idx_l1_cur;
  wire [7:0] idx_l2_cur;
  wire [7:0] idx_wr;
  wire [DW-1:0] op_a;
  wire [DW-1:0] op_b;
  wire [DW-1:0] sum;
  wire [DW-1:0] status_word;

  assign win = wptr[2:0];
  assign win_dec = win - 3'h1;
  assign win_inc = win + 3'h1;
  assign do_save = (i_op == `WRF_OP_SAVE);
  assign do_rest = (i_op == `WRF_OP_RESTORE);
  assign do_trap = (i_op == `WRF_OP_TRAP);
  assign do_tret = (i_op == `WRF_OP_TRAP_RETURN);
  assign save_ovf = do_save && inv_mask[win_dec];
  assign rest_unf = (do_rest || do_tret) && inv_mask[win_inc];
  assign priv_ok = sup;
  assign ctl_access = i_wr | i_rd_en;
  assign bad_access = ctl_access & !priv_ok;
  assign ctl_rd = i_rd_en & priv_ok;
  assign state_wr = i_wr && priv_ok && i_addr == `WRF_ADDR_STATE;
  assign mask_wr = i_wr && priv_ok && i_addr == `WRF_ADDR_MASK;
  assign status_wr = i_wr && priv_ok && i_addr == `WRF_ADDR_STATUS;
  assign clr_ovf = status_wr & i_wr_data[0];
  assign clr_unf = status_wr & i_wr_data[1];
  assign clr_priv = status_wr & i_wr_data[2];
  assign idx_a = phys(i_rs1, win);
  assign idx_b = phys(i_rs2, win);
  // Trap locals go to the window the trap opens
  assign idx_l1_trap = phys(LOCAL1_REG, win_dec);
  assign idx_l2_trap = phys(LOCAL2_REG, win_dec);
  // Return runs in the trap window, so it reads that window's locals
  assign idx_l1_cur = phys(LOCAL1_REG, win);
  assign idx_l2_cur = phys(LOCAL2_REG, win);
  assign op_a = (i_rs1 == ZERO_REG) ? {DW{1'b0}} : regs[idx_a];
  assign op_b = (i_rs2 == ZERO_REG) ? {DW{1'b0}} : regs[idx_b];
  assign sum = op_a + op_b;
  assign status_word = {{(DW-3){1'b0}}, priv_flag, unf_flag, ovf_flag};

  // Combinational next values
  reg [2:0] next_win;
  reg [DW-1:0] next_wdata;
  reg [4:0] next_wreg;
  reg next_we;
  reg [4:0] next_wptr;
  reg next_sup;
  reg next_prev_sup;
  reg [DW-1:0] next_rd_data;

  // Window step and write port selection
  always @*
  begin
    next_win = win;
    next_wdata = i_wdata;
    next_wreg = i_rd;
    next_we = i_we;
    if (do_save)
    begin
      next_we = !save_ovf;
      next_wdata = sum;
      if (!save_ovf)
        next_win = win_dec;
    end
    else if (do_rest)
    begin
      next_we = !rest_unf;
      next_wdata = sum;
      if (!rest_unf)
        next_win = win_inc;
    end
    else if (do_tret)
    begin
      next_we = 1'b0;
      if (!rest_unf)
        next_win = win_inc;
    end
    else if (do_trap)
    begin
      next_we = 1'b0;
      next_win = win_dec;
    end
  end

  assign idx_wr = phys(next_wreg, next_win);

  // A control write beats the op for the pointer
  always @*
  begin
    if (state_wr)
      next_wptr = i_wr_data[`WRF_WPTR_MSB:`WRF_WPTR_LSB];
    else
      next_wptr = {wptr[4:3], next_win};
  end

  // Traps beat control writes for the mode flags
  always @*
  begin
    next_sup = sup;
    next_prev_sup = prev_sup;
    if (do_trap)
    begin
      next_prev_sup = sup;
      next_sup = 1'b1;
    end
    else if (do_tret && !rest_unf)
    begin
      next_sup = prev_sup;
    end
    else if (state_wr)
    begin
      next_sup = i_wr_data[`WRF_SUP_BIT];
      next_prev_sup = i_wr_data[`WRF_PREV_SUP_BIT];
    end
  end

  // Refused reads return zero rather than stale data
  always @*
  begin
    next_rd_data = {DW{1'b0}};
    if (ctl_rd)
    begin
      case (i_addr)
        `WRF_ADDR_STATE:
          next_rd_data = {{(DW-8){1'b0}}, sup, prev_sup, 1'b0, wptr};
        `WRF_ADDR_MASK:
          next_rd_data = {{(DW-NW){1'b0}}, inv_mask};
        `WRF_ADDR_STATUS:
          next_rd_data = status_word;
        default:
          next_rd_data = {DW{1'b0}};
      endcase
    end
  end

  // Register storage; no reset so the array maps to plain flops
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1)
    begin : g_reg
      always @(posedge i_clk)
      begin
        if (do_trap && gi == idx_l1_trap)
          regs[gi] <= i_pc;
        else if (do_trap && gi == idx_l2_trap)
          regs[gi] <= i_next_pc;
        else if (next_we && next_wreg != ZERO_REG && gi == idx_wr)
          regs[gi] <= next_wdata;
      end
    end
  endgenerate

  // Pointer and mask hold no reset value by design
  always @(posedge i_clk)
  begin
    wptr <= next_wptr;
    if (mask_wr)
      inv_mask <= i_wr_data[NW-1:0];
  end

  // Mode flags; the output mirrors the flag in the same cycle
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sup <= `WRF_SUP_RST;
      prev_sup <= `WRF_SUP_RST;
      o_supervisor <= `WRF_SUP_RST;
    end
    else
    begin
      sup <= next_sup;
      prev_sup <= next_prev_sup;
      o_supervisor <= next_sup;
    end
  end

  // Set beats a same-cycle clear of the sticky flags
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ovf_flag <= 1'b0;
      unf_flag <= 1'b0;
      priv_flag <= 1'b0;
    end
    else
    begin
      ovf_flag <= save_ovf | (ovf_flag & !clr_ovf);
      unf_flag <= rest_unf | (unf_flag & !clr_unf);
      priv_flag <= bad_access | (priv_flag & !clr_priv);
    end
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_rdata1 <= {DW{1'b0}};
      o_rdata2 <= {DW{1'b0}};
      o_rd_data <= {DW{1'b0}};
      o_wptr <= 5'h00;
      o_overflow <= 1'b0;
      o_underflow <= 1'b0;
      o_priv_fault <= 1'b0;
      o_ret_pc <= {DW{1'b0}};
      o_ret_next_pc <= {DW{1'b0}};
      o_ret_valid <= 1'b0;
    end
    else
    begin
      o_rdata1 <= op_a;
      o_rdata2 <= op_b;
      o_rd_data <= next_rd_data;
      o_wptr <= next_wptr;
      o_overflow <= save_ovf;
      o_underflow <= rest_unf;
      o_priv_fault <= bad_access;
      // Counters for the delayed return pair come from trap locals
      o_ret_valid <= do_tret && !rest_unf;
      o_ret_pc <= regs[idx_l1_cur];
      o_ret_next_pc <= regs[idx_l2_cur];
    end
  end

endmodule // windowed_register_file
`default_nettype wire

// ### wrf_sva.sv
// Purpose: window op checks
// Assumes: one op per cycle
// Notes: mask not mirrored, faults tied to cause
`default_nettype none
`include "wrf_defines.vh"
module wrf_sva (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [2:0] i_op,
  input wire logic i_wr,
  input wire logic i_rd_en,
  input wire logic o_supervisor,
  input wire logic [4:0] o_wptr,
  input wire logic o_overflow,
  input wire logic o_underflow,
  input wire logic o_priv_fault,
  input wire logic o_ret_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  trap_mode_a: assert property (i_op == `WRF_OP_TRAP |=>
    o_supervisor) else $error("trap mode");
  trap_step_a: assert property (i_op == `WRF_OP_TRAP |=>
    o_wptr[2:0] == $past(o_wptr[2:0]) - 3'h1 && !o_overflow)
    else $error("trap step");
  save_step_a: assert property (i_op == `WRF_OP_SAVE && !i_wr |=>
    o_overflow ? $stable(o_wptr) : o_wptr[2:0] == $past(o_wptr[2:0]) - 3'h1)
    else $error("save step");
  rest_step_a: assert property (i_op == `WRF_OP_RESTORE && !i_wr |=>
    o_underflow ? $stable(o_wptr) : o_wptr[2:0] == $past(o_wptr[2:0]) + 3'h1)
    else $error("restore step");
  ovf_cause_a: assert property (o_overflow |->
    $past(i_op) == `WRF_OP_SAVE) else $error("overflow");
  unf_cause_a: assert property (o_underflow |->
    $past(i_op) inside {`WRF_OP_RESTORE, `WRF_OP_TRAP_RETURN})
    else $error("underflow");
  priv_stop_a: assert property ((i_wr || i_rd_en) && !o_supervisor |=>
    o_priv_fault) else $error("privilege");
  ret_step_a: assert property (o_ret_valid |->
    o_wptr[2:0] == $past(o_wptr[2:0]) + 3'h1) else $error("return");
endmodule // wrf_sva
bind windowed_register_file wrf_sva chk (.*);
`default_nettype wire

// ### decode_model.sv
// Purpose: decode side issuing window ops
// Assumes: two edges per op
// Notes: register numbers stay put between ops
`default_nettype none
`include "wrf_defines.vh"
module decode_model (
  input wire logic i_clk,
  output logic [2:0] i_op,
  output logic [4:0] i_rs1,
  output logic [4:0] i_rs2,
  output logic [4:0] i_rd,
  output logic i_we,
  output logic [31:0] i_wdata,
  output logic [31:0] i_pc,
  output logic [31:0] i_next_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {i_op, i_rs1, i_rs2, i_rd, i_we, i_wdata} = '0;
    i_pc = 32'h100;
    i_next_pc = 32'h104;
  end
  // Counters step per op so a trap stores fresh values
  task automatic issue(input logic [2:0] op, input logic [4:0] a = 5'h0,
    input logic [4:0] b = 5'h0, input logic [4:0] d = 5'h0,
    input logic we = 1'b0, input logic [31:0] wd = 32'h0);
    @(posedge i_clk);
    {i_op, i_rs1, i_rs2, i_rd, i_we, i_wdata} <= {op, a, b, d, we, wd};
    i_pc <= i_next_pc;
    i_next_pc <= i_next_pc + 32'h4;
    @(posedge i_clk);
    i_op <= `WRF_OP_NONE;
    i_we <= 1'b0;
    #1;
  endtask
endmodule // decode_model
`default_nettype wire

// ### windowed_register_file_tb.sv
// Purpose: directed window test
// Assumes: supervisor after reset
// Notes: every op and access is two edges
`default_nettype none
`include "wrf_defines.vh"
module windowed_register_file_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_nrst, i_wr, i_rd_en, i_we, o_supervisor, o_overflow;
  logic o_underflow, o_priv_fault, o_ret_valid;
  logic [2:0] i_op;
  logic [3:0] i_addr;
  logic [4:0] i_rs1, i_rs2, i_rd, o_wptr;
  logic [31:0] i_wdata, i_pc, i_next_pc, i_wr_data, o_rdata1, o_rdata2;
  logic [31:0] o_rd_data, o_ret_pc, o_ret_next_pc, tpc, tnext;
  int n_mismatch = 0;
  int checks_done = 0;
  windowed_register_file dut (.*);
  decode_model dm (.*);
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic ck(input logic [31:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Write when w, else read and compare with d
  task automatic acc(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge i_clk);
    {i_wr, i_rd_en, i_addr, i_wr_data} <= {w, !w, a, d};
    @(posedge i_clk);
    {i_wr, i_rd_en} <= 2'h0;
    #1;
    if (!w)
      ck(o_rd_data, d);
  endtask
  task automatic rg(input logic [4:0] n, input logic [31:0] e);
    dm.issue(`WRF_OP_NONE, n);
    ck(o_rdata1, e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    {i_nrst, i_wr, i_rd_en, i_addr, i_wr_data} = '0;
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    ck(32'(o_supervisor), 32'h1);
    acc(1'b1, `WRF_ADDR_STATE, 32'h80);
    acc(1'b1, `WRF_ADDR_MASK, 32'h80);
    acc(1'b0, `WRF_ADDR_STATE, 32'h80);
    acc(1'b0, 4'hC, 32'h0);
    dm.issue(`WRF_OP_SAVE);
    ck(32'({o_overflow, o_wptr}), 32'h20);
    acc(1'b1, `WRF_ADDR_MASK, 32'h2);
    dm.issue(`WRF_OP_NONE, , , 5'h1, 1'b1, 32'h5);
    dm.issue(`WRF_OP_NONE, , , 5'h0, 1'b1, 32'hFF);
    dm.issue(`WRF_OP_NONE, , , 5'h8, 1'b1, 32'hA0);
    rg(5'h0, 32'h0);
    dm.issue(`WRF_OP_SAVE, 5'h8, 5'h1, 5'h10);
    ck(32'({o_overflow, o_wptr}), 32'h7);
    dm.issue(`WRF_OP_NONE, 5'h18, 5'h10);
    ck(o_rdata2, 32'hA5);
    rg(5'h18, 32'hA0);
    rg(5'h10, 32'hA5);
    rg(5'h1, 32'h5);
    dm.issue(`WRF_OP_RESTORE);
    ck(32'({o_underflow, o_wptr}), 32'h0);
    dm.issue(`WRF_OP_RESTORE);
    ck(32'({o_underflow, o_wptr}), 32'h20);
    acc(1'b1, `WRF_ADDR_MASK, 32'h80);
    acc(1'b1, `WRF_ADDR_STATE, 32'h0);
    acc(1'b1, `WRF_ADDR_MASK, 32'hFF);
    ck(32'({o_priv_fault, o_supervisor}), 32'h2);
    dm.issue(`WRF_OP_TRAP);
    tpc = i_pc;
    tnext = i_next_pc;
    ck(32'({o_overflow, o_supervisor, o_wptr}), 32'h27);
    acc(1'b0, `WRF_ADDR_MASK, 32'h80);
    acc(1'b0, `WRF_ADDR_STATUS, 32'h7);
    rg(5'h11, tpc);
    rg(5'h12, tnext);
    dm.issue(`WRF_OP_TRAP_RETURN);
    ck(32'({o_ret_valid, o_supervisor, o_wptr}), 32'h40);
    ck(o_ret_pc, tpc);
    ck(o_ret_next_pc, tnext);
    tally_and_finish;
  end
endmodule // windowed_register_file_tb
`default_nettype wire
